// [dimm_layout_descriptor_regs.v]
// How it works
// - bits 12:10 hold the first logical rank of the slot.
// - bit 9 set means the slot is populated.
// - bits 8:7 bank count: 00 four, 01 eight, 10 sixteen.
// - bits 6:5 rank count: 00 single, 01 double, 10 quad.
// - bits 4:2 row count: codes 000..100 give 2^12..2^16 rows.
// - bits 1:0 column count: 2^10, 2^11, 2^12; code 11 reserved.
//
// Local design decisions: the strobed register port and the address map.
`include "layout_defines.vh"

module dimm_layout_descriptor_regs (
    // Clock and reset
    input  wire                 clk,
    input  wire                 nrst,
    // Register port
    input  wire [`ADDR_W-1:0]   addr,
    input  wire [31:0]          wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [31:0]          rdata,
    // Channel 0 fields to the address decoder
    output reg  [8:0]           ch0_first_rank_index,
    output reg  [2:0]           ch0_slot_populated,
    output reg  [5:0]           ch0_bank_count_code,
    output reg  [5:0]           ch0_rank_count_code,
    output reg  [8:0]           ch0_row_count_code,
    output reg  [5:0]           ch0_column_count_code,
    // Channel 1 fields to the address decoder
    output reg  [8:0]           ch1_first_rank_index,
    output reg  [2:0]           ch1_slot_populated,
    output reg  [5:0]           ch1_bank_count_code,
    output reg  [5:0]           ch1_rank_count_code,
    output reg  [8:0]           ch1_row_count_code,
    output reg  [5:0]           ch1_column_count_code,
    // Set while any populated slot holds a reserved code
    output reg                  layout_code_error
);

    reg                 rst_meta;
    reg                 rst_sync;
    wire                rst_n;
    wire [`DESC_W-1:0]  desc [0:5];
    reg  [5:0]          sel;
    reg  [31:0]         next_rdata;
    reg                 next_error;
    wire [8:0]          next_ch0_first_rank_index;
    wire [2:0]          next_ch0_slot_populated;
    wire [5:0]          next_ch0_bank_count_code;
    wire [5:0]          next_ch0_rank_count_code;
    wire [8:0]          next_ch0_row_count_code;
    wire [5:0]          next_ch0_column_count_code;
    wire [8:0]          next_ch1_first_rank_index;
    wire [2:0]          next_ch1_slot_populated;
    wire [5:0]          next_ch1_bank_count_code;
    wire [5:0]          next_ch1_rank_count_code;
    wire [8:0]          next_ch1_row_count_code;
    wire [5:0]          next_ch1_column_count_code;
    integer             i;
    integer             j;

    // Asynchronous assert, synchronous release
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    assign rst_n = rst_sync;

    // Address decode, one select per descriptor
    always @* begin
        sel = 6'h00;
        case (addr)
            `IDX_CH0_SLOT0: sel = 6'h01;
            `IDX_CH0_SLOT1: sel = 6'h02;
            `IDX_CH0_SLOT2: sel = 6'h04;
            `IDX_CH1_SLOT0: sel = 6'h08;
            `IDX_CH1_SLOT1: sel = 6'h10;
            `IDX_CH1_SLOT2: sel = 6'h20;
            default:        sel = 6'h00;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : slot
            layout_slot u_slot (
                .clk     (clk),
                .rst_n   (rst_n),
                .wr_en   (wr & sel[g]),
                .wr_data (wdata[`DESC_W-1:0]),
                .desc    (desc[g])
            );
        end
    endgenerate

    // Read mux; upper bits and unmapped addresses read zero
    always @* begin
        next_rdata = `UNMAPPED_DATA;
        for (i = 0; i < `NUM_DESC; i = i + 1) begin
            if (sel[i]) begin
                next_rdata = {{(32-`DESC_W){1'b0}}, desc[i]};
            end
        end
    end

    // Reserved-code watch; the decoder result is undefined for these
    always @* begin
        next_error = 1'b0;
        for (j = 0; j < `NUM_DESC; j = j + 1) begin
            if (desc[j][`F_POP] &&
                ((desc[j][`F_BANK_HI:`F_BANK_LO] == `BANK_RSVD) ||
                 (desc[j][`F_RCNT_HI:`F_RCNT_LO] == `RCNT_RSVD) ||
                 (desc[j][`F_ROW_HI:`F_ROW_LO] > `ROW_MAX) ||
                 (desc[j][`F_COL_HI:`F_COL_LO] == `COL_RSVD))) begin
                next_error = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `UNMAPPED_DATA;
        end else begin
            rdata <= rd ? next_rdata : `UNMAPPED_DATA;
        end
    end

    // Level flag, follows the stored codes with one cycle of delay
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            layout_code_error <= 1'b0;
        end else begin
            layout_code_error <= next_error;
        end
    end

    // Field vectors gathered per slot, slot s at its own slice
    generate
        for (g = 0; g < `SLOTS_PER_CH; g = g + 1) begin : field
            assign next_ch0_first_rank_index[3*g +: 3] =
                desc[g][`F_RANK_HI:`F_RANK_LO];
            assign next_ch1_first_rank_index[3*g +: 3] =
                desc[g+`SLOTS_PER_CH][`F_RANK_HI:`F_RANK_LO];
            assign next_ch0_slot_populated[g] =
                desc[g][`F_POP];
            assign next_ch1_slot_populated[g] =
                desc[g+`SLOTS_PER_CH][`F_POP];
            assign next_ch0_bank_count_code[2*g +: 2] =
                desc[g][`F_BANK_HI:`F_BANK_LO];
            assign next_ch1_bank_count_code[2*g +: 2] =
                desc[g+`SLOTS_PER_CH][`F_BANK_HI:`F_BANK_LO];
            assign next_ch0_rank_count_code[2*g +: 2] =
                desc[g][`F_RCNT_HI:`F_RCNT_LO];
            assign next_ch1_rank_count_code[2*g +: 2] =
                desc[g+`SLOTS_PER_CH][`F_RCNT_HI:`F_RCNT_LO];
            assign next_ch0_row_count_code[3*g +: 3] =
                desc[g][`F_ROW_HI:`F_ROW_LO];
            assign next_ch1_row_count_code[3*g +: 3] =
                desc[g+`SLOTS_PER_CH][`F_ROW_HI:`F_ROW_LO];
            assign next_ch0_column_count_code[2*g +: 2] =
                desc[g][`F_COL_HI:`F_COL_LO];
            assign next_ch1_column_count_code[2*g +: 2] =
                desc[g+`SLOTS_PER_CH][`F_COL_HI:`F_COL_LO];
        end
    endgenerate

    // Channel 0 outputs; registered so the decoder sees no mux glitches
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch0_first_rank_index  <= `VEC9_RESET;
            ch0_slot_populated    <= `VEC3_RESET;
            ch0_bank_count_code   <= `VEC6_RESET;
            ch0_rank_count_code   <= `VEC6_RESET;
            ch0_row_count_code    <= `VEC9_RESET;
            ch0_column_count_code <= `VEC6_RESET;
        end else begin
            ch0_first_rank_index  <= next_ch0_first_rank_index;
            ch0_slot_populated    <= next_ch0_slot_populated;
            ch0_bank_count_code   <= next_ch0_bank_count_code;
            ch0_rank_count_code   <= next_ch0_rank_count_code;
            ch0_row_count_code    <= next_ch0_row_count_code;
            ch0_column_count_code <= next_ch0_column_count_code;
        end
    end

    // Channel 1 outputs, same one-cycle lag as channel 0
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch1_first_rank_index  <= `VEC9_RESET;
            ch1_slot_populated    <= `VEC3_RESET;
            ch1_bank_count_code   <= `VEC6_RESET;
            ch1_rank_count_code   <= `VEC6_RESET;
            ch1_row_count_code    <= `VEC9_RESET;
            ch1_column_count_code <= `VEC6_RESET;
        end else begin
            ch1_first_rank_index  <= next_ch1_first_rank_index;
            ch1_slot_populated    <= next_ch1_slot_populated;
            ch1_bank_count_code   <= next_ch1_bank_count_code;
            ch1_rank_count_code   <= next_ch1_rank_count_code;
            ch1_row_count_code    <= next_ch1_row_count_code;
            ch1_column_count_code <= next_ch1_column_count_code;
        end
    end

endmodule // dimm_layout_descriptor_regs

// [layout_defines.vh]
`ifndef LAYOUT_DEFINES_VH
`define LAYOUT_DEFINES_VH

// Register indices; the addr port carries the index itself, not a byte address
`define ADDR_W             8
`define IDX_CH0_SLOT0      8'h00
`define IDX_CH0_SLOT1      8'h01
`define IDX_CH0_SLOT2      8'h02
`define IDX_CH1_SLOT0      8'h03
`define IDX_CH1_SLOT1      8'h04
`define IDX_CH1_SLOT2      8'h05
`define NUM_DESC           6
`define SLOTS_PER_CH       3

// Descriptor field layout
`define DESC_W             13
`define F_RANK_HI          12
`define F_RANK_LO          10
`define F_POP              9
`define F_BANK_HI          8
`define F_BANK_LO          7
`define F_RCNT_HI          6
`define F_RCNT_LO          5
`define F_ROW_HI           4
`define F_ROW_LO           2
`define F_COL_HI           1
`define F_COL_LO           0

`define DESC_RESET         13'h0000
`define UNMAPPED_DATA      32'h00000000
`define VEC9_RESET         9'h000
`define VEC6_RESET         6'h00
`define VEC3_RESET         3'h0

// Reserved code checks
`define BANK_RSVD          2'h3
`define RCNT_RSVD          2'h3
`define ROW_MAX            3'h4
`define COL_RSVD           2'h3

`endif

// [layout_slot.v]
`include "layout_defines.vh"

module layout_slot (
    // Clock and reset
    input  wire                 clk,
    input  wire                 rst_n,
    // Write access
    input  wire                 wr_en,
    input  wire [`DESC_W-1:0]   wr_data,
    // Stored descriptor
    output reg  [`DESC_W-1:0]   desc
);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            desc <= `DESC_RESET;
        end else if (wr_en) begin
            desc <= wr_data;
        end
    end

endmodule // layout_slot

// [layout_checker_properties.sv]
module layout_checker (
    input logic        clk, nrst, wr, rd,
    input logic [7:0]  addr,
    input logic [31:0] wdata, rdata,
    input logic [8:0]  ch0_first_rank_index, ch0_row_count_code,
    input logic [2:0]  ch0_slot_populated,
    input logic [5:0]  ch0_bank_count_code, ch0_rank_count_code,
    input logic [5:0]  ch0_column_count_code,
    input logic        layout_code_error
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    rank_index_a: assert property (wr && addr == 8'h00 |-> ##2
        ch0_first_rank_index[2:0] == $past(wdata[12:10], 2)) else $error("rank");
    slot_pop_a: assert property (wr && addr == 8'h00 |-> ##2
        ch0_slot_populated[0] == $past(wdata[9], 2)) else $error("populated");
    bank_code_a: assert property (wr && addr == 8'h00 |-> ##2
        ch0_bank_count_code[1:0] == $past(wdata[8:7], 2)) else $error("bank");
    rank_code_a: assert property (wr && addr == 8'h00 |-> ##2
        ch0_rank_count_code[1:0] == $past(wdata[6:5], 2)) else $error("ranks");
    row_code_a: assert property (wr && addr == 8'h01 |-> ##2
        ch0_row_count_code[5:3] == $past(wdata[4:2], 2)) else $error("row");
    col_code_a: assert property (wr && addr == 8'h02 |-> ##2
        ch0_column_count_code[5:4] == $past(wdata[1:0], 2)) else $error("col");
    read_back_a: assert property (rd && addr == 8'h00 && !$past(wr) |=>
        rdata == {19'h0, ch0_first_rank_index[2:0], ch0_slot_populated[0],
        ch0_bank_count_code[1:0], ch0_rank_count_code[1:0],
        ch0_row_count_code[2:0], ch0_column_count_code[1:0]})
        else $error("read data");
    // Data only in the cycle after a mapped read
    idle_rdata_a: assert property (!rd || addr > 8'h05 |=> rdata == 32'h0)
        else $error("rdata not zero");
    code_error_a: assert property (wr && addr <= 8'h05 && wdata[9] &&
        wdata[8:7] == 2'h3 |-> ##2 layout_code_error) else $error("flag");
    cover property (layout_code_error);
    cover property (wr && addr == 8'h02);
    cover property (rd && addr > 8'h05);
    cover property (rd && addr == 8'h00 && !$past(wr));
endmodule // layout_checker

// [testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, nrst = 0, wr = 0, rd = 0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [8:0]  fr0, fr1, rw0, rw1;
    logic [2:0]  pp0, pp1;
    logic [5:0]  bk0, bk1, rk0, rk1, cl0, cl1;
    logic        err_flag;
    int          err_count = 0, compares = 0;
    always #10 clk = ~clk;
    dimm_layout_descriptor_regs dimm_layout_descriptor_regs_inst (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ch0_first_rank_index(fr0), .ch0_slot_populated(pp0),
        .ch0_bank_count_code(bk0), .ch0_rank_count_code(rk0),
        .ch0_row_count_code(rw0), .ch0_column_count_code(cl0),
        .ch1_first_rank_index(fr1), .ch1_slot_populated(pp1),
        .ch1_bank_count_code(bk1), .ch1_rank_count_code(rk1),
        .ch1_row_count_code(rw1), .ch1_column_count_code(cl1),
        .layout_code_error(err_flag));
    task chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    function automatic logic [31:0] fields(int i);
        int s = i % 3;
        if (i < 3)
            return {fr0[3*s+:3], pp0[s], bk0[2*s+:2], rk0[2*s+:2],
                    rw0[3*s+:3], cl0[2*s+:2]};
        return {fr1[3*s+:3], pp1[s], bk1[2*s+:2], rk1[2*s+:2],
                rw1[3*s+:3], cl1[2*s+:2]};
    endfunction
    task t_reset;
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            rd_reg(i[7:0], d);
            chk(d, 32'h0);
            chk(fields(i), 32'h0);
        end
    endtask
    // Writes off the map must not alias onto a real slot
    task t_unmapped;
        logic [31:0] d;
        wr_reg(8'h06, 32'h1fff);
        wr_reg(8'hff, 32'h1fff);
        rd_reg(8'h06, d);
        chk(d, 32'h0);
        rd_reg(8'h00, d);
        chk(d, 32'h0);
        chk(fields(5), 32'h0);
    endtask
    task t_codes;
        logic [31:0] d;
        logic [12:0] v[6];
        for (int k = 0; k < 5; k++) begin
            for (int i = 0; i < 6; i++) begin
                // first rank by slot; odd k means two modules
                // only legal bank, rank, row and column codes
                v[i] = {(i % 3 == 0) ? 3'h0 : (i % 3 == 2 || k[0]) ? 3'h4
                        : 3'h2, 1'b1, 2'((k + i) % 3), 2'(k % 3), 3'(k),
                        2'((k + i) % 3)};
                wr_reg(i[7:0], {19'h7ffff, v[i]});
            end
            for (int i = 0; i < 6; i++) begin
                rd_reg(i[7:0], d);
                chk(d, {19'h0, v[i]});
                chk(fields(i), {19'h0, v[i]});
            end
        end
    endtask
    // Reserved codes are stored; the flag counts populated slots only
    task t_reserved;
        logic [31:0] d;
        logic [31:0] w[6] = '{32'h180, 32'h380, 32'h260, 32'h214,
                              32'h203, 32'h200};
        for (int n = 0; n < 6; n++) begin
            wr_reg(8'h01, w[n]);
            @(posedge clk);
            #1 chk(err_flag, (n > 0 && n < 5) ? 32'h1 : 32'h0);
            rd_reg(8'h01, d);
            chk(d, w[n]);
        end
        wr_reg(8'h01, 32'h0);
    endtask
    // Reset in mid-run clears every descriptor at once
    task t_midrun_reset;
        @(posedge clk) nrst <= 1'b0;
        @(posedge clk);
        #1 chk(fields(4), 32'h0);
        chk(err_flag, 32'h0);
        @(posedge clk) nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
    endtask
    task print_verdict;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset;
        t_unmapped;
        t_codes;
        t_reserved;
        t_midrun_reset;
        print_verdict;
    end
    initial begin
        #100000;
        err_count++;
        print_verdict;
    end
endmodule // testbench
bind dimm_layout_descriptor_regs layout_checker layout_checker_inst (
    .clk(clk), .nrst(nrst), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .ch0_first_rank_index(ch0_first_rank_index),
    .ch0_row_count_code(ch0_row_count_code),
    .ch0_slot_populated(ch0_slot_populated),
    .ch0_bank_count_code(ch0_bank_count_code),
    .ch0_rank_count_code(ch0_rank_count_code),
    .ch0_column_count_code(ch0_column_count_code),
    .layout_code_error(layout_code_error));
